// ===== include/rcl_pkg.sv
`default_nettype none
package rcl_pkg;
  // Role switch and remote configuration
  typedef enum logic [1:0] {
    RCL_SW_CLEAR = 2'h0,
    RCL_SW_A = 2'h1,
    RCL_SW_B = 2'h2
  } rcl_switch_t;

  // Remote run state
  typedef enum logic [1:0] {
    RCL_RUN_INDET = 2'h0,
    RCL_RUN_RUN = 2'h1,
    RCL_RUN_STOP = 2'h2
  } rcl_run_t;

  // Redundancy role of a unit
  typedef enum logic [1:0] {
    RCL_ROLE_WAIT = 2'h0,
    RCL_ROLE_PRIMARY = 2'h1,
    RCL_ROLE_STANDBY = 2'h2
  } rcl_role_t;

  // Network link speed code
  typedef enum logic [1:0] {
    RCL_SPD_NONE = 2'h0,
    RCL_SPD_10M = 2'h1,
    RCL_SPD_100M = 2'h2
  } rcl_speed_t;

  // Fixed front-panel indicators
  typedef struct packed {
    logic unit_a;
    logic unit_b;
    logic remote_run;
    logic primary_role_led;
    logic standby_role_led;
    logic link_green;
    logic card_access;
    logic card_led_a;
    logic no_config;
    logic safety_run_led;
    logic safety_mode_led;
  } rcl_panel_t;
endpackage
`default_nettype wire

// ===== include/rcl_regs.svh
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH

// Clock and pattern timing
`define RCL_CLK_HZ 50000000
`define RCL_FLASH_HALF_MS 250
`define RCL_BLINK_HALF_MS 500
`define RCL_FLASH_HALF_CYC ((`RCL_CLK_HZ / 1000) * `RCL_FLASH_HALF_MS)
`define RCL_BLINK_HALF_CYC ((`RCL_CLK_HZ / 1000) * `RCL_BLINK_HALF_MS)

// Byte offsets of the register words
`define RCL_OFF_ROLE 8'h00
`define RCL_OFF_STATE 8'h04
`define RCL_OFF_LINK 8'h08
`define RCL_OFF_PORT 8'h0C
`define RCL_OFF_CARD 8'h10
`define RCL_OFF_SAFETY 8'h14
`define RCL_OFF_LEDSTAT 8'h18

// Word indices and count of writable words
`define RCL_IDX_ROLE 3'h0
`define RCL_IDX_STATE 3'h1
`define RCL_IDX_LINK 3'h2
`define RCL_IDX_PORT 3'h3
`define RCL_IDX_CARD 3'h4
`define RCL_IDX_SAFETY 3'h5
`define RCL_IDX_LEDSTAT 3'h6
`define RCL_NUM_WR 3'h6

// Writable bit masks; other bits read as zero
`define RCL_MASK_ROLE 32'h0000000F
`define RCL_MASK_STATE 32'h0000007F
`define RCL_MASK_LINK 32'h00000007
`define RCL_MASK_PORT 32'h0000FF0F
`define RCL_MASK_CARD 32'h0000001F
`define RCL_MASK_SAFETY 32'h00000003

// Reset values
`define RCL_RST_WORD 32'h00000000

// ROLE fields
`define RCL_ROLE_LOCAL 1:0
`define RCL_ROLE_REMOTE 3:2
// STATE fields
`define RCL_ST_RRUN 1:0
`define RCL_ST_LOCAL 3:2
`define RCL_ST_REMOTE 5:4
`define RCL_ST_WAIT_DARK 6
// LINK fields
`define RCL_LINK_CFG 0
`define RCL_LINK_OPER 1
`define RCL_LINK_CONN 2
// PORT fields: activity bit i, speed at 8+2i
`define RCL_PORT_ACT_LSB 0
`define RCL_PORT_SPD_LSB 8
// CARD fields
`define RCL_CARD_PRESENT 0
`define RCL_CARD_RECOG 1
`define RCL_CARD_ACCESS 2
`define RCL_CARD_SAFE_RM 3
`define RCL_CARD_CARD_LED_A 4
// SAFETY fields
`define RCL_SAF_RUN 0
`define RCL_SAF_MODE 1
// LEDSTAT port field positions
`define RCL_LS_ACT_LSB 16
`define RCL_LS_LNKG_LSB 20
`define RCL_LS_LNKY_LSB 24

`endif

// ===== logic/rcl_led_top.sv
// Behaviour
// - Switch A with remote B lights A steadily, B dark.
// - Switch B with remote A lights B steadily, A dark.
// - Same role on both units flashes that role's indicator, other dark.
// - Switch in clear position flashes both A and B.
// - Remote run on when running, flashing when stopped, dark if unknown.
// - Primary/standby indicators follow local and remote role table.
// - Link indicator steady green while exchanging traffic with remote.
// - Link indicator blinks when configured, operational, not connected.
// - Link indicator dark when unconfigured or not operational.
// - Port activity flashes green during transmission, dark otherwise.
// - Port link green at 100 Mbit/s, yellow at 10, dark without link.
// - Card indicator steady when card recognized and idle.
// - Card indicator flashes while the card is being accessed.
// - Card indicator blinks when an inserted card is unrecognized.
// - Card indicator dark when card may be removed safely.
// - No card: card and card_led_a indicators dark, no configuration shown.
// - Safety indicators driven only on safety variants, else unused.
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.svh"
module rcl_led_top #(
  parameter int unsigned NUM_PORTS = 2,
  parameter bit SAFETY_VARIANT = 1'b0,
  parameter int unsigned FLASH_HALF_CYC = `RCL_FLASH_HALF_CYC,
  parameter int unsigned BLINK_HALF_CYC = `RCL_BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Panel indicators
  output var rcl_pkg::rcl_panel_t panel,
  // Network port indicators
  output logic [NUM_PORTS-1:0] port_activity_led,
  output logic [NUM_PORTS-1:0] port_link_led_green,
  output logic [NUM_PORTS-1:0] port_link_led_yellow
);
  // Register words, byte offsets, 32 bits each:
  //   0x00 role switch: [1:0] local setting, [3:2] remote setting,
  //        coded 0 clear, 1 unit A, 2 unit B
  //   0x04 unit state: [1:0] remote run, 0 unknown, 1 run, 2 stop
  //        [3:2] local role and [5:4] remote role,
  //        coded 0 wait, 1 primary, 2 standby
  //        [6] a waiting unit shows a dark pair instead of flashing
  //   0x08 redundancy link: [0] configured, [1] operational,
  //        [2] exchanging traffic with the remote unit
  //   0x0C network ports: [i] activity of port i,
  //        [8+2i +: 2] speed, 0 none, 1 10 Mbit/s, 2 100 Mbit/s
  //   0x10 memory card: [0] present, [1] recognized, [2] accessing,
  //        [3] safe to remove, [4] card_led_a request
  //   0x14 safety: [0] run, [1] mode; inert unless SAFETY_VARIANT
  //   0x18 indicator picture, read-only: [10:0] panel with unit_a on
  //        top, [16+i] activity, [20+i] link green, [24+i] link yellow
  //   0x1C and all from 0x20 up read zero and ignore writes
  // Limitation: the picture has room for four ports, so NUM_PORTS
  // must stay at four or below.
  // Every access costs exactly one wait cycle; a new request may
  // start in the cycle after the answer.
  // One struct holds all state but the pattern generators: bus answer, words, indicator flops.
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [5:0][31:0] regs;
    rcl_pkg::rcl_panel_t panel;
    logic [NUM_PORTS-1:0] act;
    logic [NUM_PORTS-1:0] lnk_g;
    logic [NUM_PORTS-1:0] lnk_y;
  } rcl_state_t;

  rcl_state_t s, n;
  logic flash;
  logic blink;

  // Two pattern sources; blink is slower so the two look different.
  // Both start dark after reset and share one reset, so their edges
  // stay in a fixed relation; nothing else on the panel keeps time.
  rcl_pattern_gen #(.HALF_CYC(FLASH_HALF_CYC)) u_flash (
    .core_clk(core_clk),
    .rstn(rstn),
    .wave(flash)
  );

  rcl_pattern_gen #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
    .core_clk(core_clk),
    .rstn(rstn),
    .wave(blink)
  );

  // Writable bits of each word
  // Bits outside a mask stay zero, so readback shows what is in use
  function automatic logic [31:0] wr_mask(input logic [2:0] idx);
    case (idx)
      `RCL_IDX_ROLE: wr_mask = `RCL_MASK_ROLE;
      `RCL_IDX_STATE: wr_mask = `RCL_MASK_STATE;
      `RCL_IDX_LINK: wr_mask = `RCL_MASK_LINK;
      `RCL_IDX_PORT: wr_mask = `RCL_MASK_PORT;
      `RCL_IDX_CARD: wr_mask = `RCL_MASK_CARD;
      `RCL_IDX_SAFETY: wr_mask = `RCL_MASK_SAFETY;
      default: wr_mask = 32'h00000000;
    endcase
  endfunction

  // Next state: bus slave, then indicator decode
  always_comb begin
    // Bus decode
    logic [2:0] idx;
    logic hit;
    logic req;
    logic [31:0] bmask;
    logic [31:0] ledstat;
    logic [31:0] rword;
    // Fields taken out of the register words
    rcl_pkg::rcl_switch_t sw_loc;
    rcl_pkg::rcl_switch_t sw_rem;
    rcl_pkg::rcl_run_t rrun;
    rcl_pkg::rcl_role_t r_loc;
    rcl_pkg::rcl_role_t r_rem;
    rcl_pkg::rcl_speed_t spd;
    logic [31:0] cr;
    logic [31:0] lk;

    // Word index from the byte address; the low two bits are ignored
    idx = avs_address[4:2];
    hit = (avs_address[7:5] == 3'h0);
    req = avs_read | avs_write;
    bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    ledstat = 32'h00000000;
    rword = 32'h00000000;
    sw_loc = rcl_pkg::rcl_switch_t'(s.regs[`RCL_IDX_ROLE][`RCL_ROLE_LOCAL]);
    sw_rem = rcl_pkg::rcl_switch_t'(s.regs[`RCL_IDX_ROLE][`RCL_ROLE_REMOTE]);
    rrun = rcl_pkg::rcl_run_t'(s.regs[`RCL_IDX_STATE][`RCL_ST_RRUN]);
    r_loc = rcl_pkg::rcl_role_t'(s.regs[`RCL_IDX_STATE][`RCL_ST_LOCAL]);
    r_rem = rcl_pkg::rcl_role_t'(s.regs[`RCL_IDX_STATE][`RCL_ST_REMOTE]);
    spd = rcl_pkg::RCL_SPD_NONE;
    cr = s.regs[`RCL_IDX_CARD];
    lk = s.regs[`RCL_IDX_LINK];
    n = s;

    // Live indicator picture for software
    // It shows the flops, so a read sees what the panel shows now
    ledstat[10:0] = s.panel;
    ledstat[`RCL_LS_ACT_LSB +: NUM_PORTS] = s.act;
    ledstat[`RCL_LS_LNKG_LSB +: NUM_PORTS] = s.lnk_g;
    ledstat[`RCL_LS_LNKY_LSB +: NUM_PORTS] = s.lnk_y;
    if (hit && idx < `RCL_NUM_WR) begin
      rword = s.regs[idx];
    end else if (hit && idx == `RCL_IDX_LEDSTAT) begin
      rword = ledstat;
    end

    // One wait cycle per request; registered answer drops waitrequest.
    // The read word is caught when the request is taken, so it stands
    // unchanged through the cycle in which waitrequest is low.
    n.ack = req & ~s.ack;
    if (req && !s.ack) begin
      n.rdata = avs_read ? rword : 32'h00000000;
    end

    // Write lands at the edge where waitrequest is seen low
    // Byte lanes and the writable mask both gate each bit
    if (avs_write && s.ack && hit && idx < `RCL_NUM_WR) begin
      n.regs[idx] = (s.regs[idx] & ~(bmask & wr_mask(idx)))
                  | (avs_writedata & bmask & wr_mask(idx));
    end

    // Unit A/B indicators
    case (sw_loc)
      rcl_pkg::RCL_SW_A: begin
        if (sw_rem == rcl_pkg::RCL_SW_A) begin
          n.panel.unit_a = flash;
        end else begin
          n.panel.unit_a = 1'b1;
        end
        n.panel.unit_b = 1'b0;
      end
      rcl_pkg::RCL_SW_B: begin
        n.panel.unit_a = 1'b0;
        if (sw_rem == rcl_pkg::RCL_SW_B) begin
          n.panel.unit_b = flash;
        end else begin
          n.panel.unit_b = 1'b1;
        end
      end
      default: begin
        // Code 3 of the switch field is taken as clear as well
        n.panel.unit_a = flash;
        n.panel.unit_b = flash;
      end
    endcase

    // Remote run state
    // Code 3 is unused and reads as an unknown remote, so dark
    case (rrun)
      rcl_pkg::RCL_RUN_RUN: n.panel.remote_run = 1'b1;
      rcl_pkg::RCL_RUN_STOP: n.panel.remote_run = flash;
      default: n.panel.remote_run = 1'b0;
    endcase

    // Primary and standby roles
    // With local role primary, a remote role of wait makes the standby indicator flash
    case (r_loc)
      rcl_pkg::RCL_ROLE_PRIMARY: begin
        n.panel.primary_role_led = 1'b1;
        if (r_rem == rcl_pkg::RCL_ROLE_WAIT) begin
          n.panel.standby_role_led = flash;
        end else begin
          n.panel.standby_role_led = 1'b0;
        end
      end
      rcl_pkg::RCL_ROLE_STANDBY: begin
        n.panel.primary_role_led = 1'b0;
        n.panel.standby_role_led = 1'b1;
      end
      default: begin
        // Waiting: software picks flashing pair or dark pair
        if (s.regs[`RCL_IDX_STATE][`RCL_ST_WAIT_DARK]) begin
          n.panel.primary_role_led = 1'b0;
          n.panel.standby_role_led = 1'b0;
        end else begin
          n.panel.primary_role_led = flash;
          n.panel.standby_role_led = flash;
        end
      end
    endcase

    // Redundancy link; connected only counts on a working port
    // Blink, not flash, so a missing link stands out from traffic
    if (!lk[`RCL_LINK_CFG] || !lk[`RCL_LINK_OPER]) begin
      n.panel.link_green = 1'b0;
    end else if (lk[`RCL_LINK_CONN]) begin
      n.panel.link_green = 1'b1;
    end else begin
      n.panel.link_green = blink;
    end

    // Network ports
    // Activity is a level from software gated by the flash wave;
    // speed code 3 is reserved and leaves both colours dark
    for (int i = 0; i < NUM_PORTS; i++) begin
      spd = rcl_pkg::rcl_speed_t'(
        s.regs[`RCL_IDX_PORT][`RCL_PORT_SPD_LSB + 2 * i +: 2]);
      n.act[i] = s.regs[`RCL_IDX_PORT][`RCL_PORT_ACT_LSB + i]
               & flash;
      n.lnk_g[i] = (spd == rcl_pkg::RCL_SPD_100M);
      n.lnk_y[i] = (spd == rcl_pkg::RCL_SPD_10M);
    end

    // Memory card; safe-removal wins so the user sees dark first
    // An unrecognized card blinks rather than going dark, so it can
    // be told apart from a card that is safe to pull
    if (!cr[`RCL_CARD_PRESENT]) begin
      n.panel.card_access = 1'b0;
    end else if (cr[`RCL_CARD_SAFE_RM]) begin
      n.panel.card_access = 1'b0;
    end else if (!cr[`RCL_CARD_RECOG]) begin
      n.panel.card_access = blink;
    end else if (cr[`RCL_CARD_ACCESS]) begin
      n.panel.card_access = flash;
    end else begin
      n.panel.card_access = 1'b1;
    end
    n.panel.card_led_a = cr[`RCL_CARD_PRESENT]
                       & cr[`RCL_CARD_CARD_LED_A];
    n.panel.no_config = ~cr[`RCL_CARD_PRESENT];

    // Safety indicators held dark on non-safety builds
    // The words still store what software writes, for readback
    n.panel.safety_run_led = SAFETY_VARIANT
      & s.regs[`RCL_IDX_SAFETY][`RCL_SAF_RUN];
    n.panel.safety_mode_led = SAFETY_VARIANT
      & s.regs[`RCL_IDX_SAFETY][`RCL_SAF_MODE];
  end

  // State register; synchronous reset returns all words to zero
  // and every indicator dark, with waitrequest high
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flops
  // waitrequest is the inverse of the answer flop: high when idle
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = ~s.ack;
  assign panel = s.panel;
  assign port_activity_led = s.act;
  assign port_link_led_green = s.lnk_g;
  assign port_link_led_yellow = s.lnk_y;
endmodule // rcl_led_top
`default_nettype wire

// ===== logic/rcl_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.svh"
module rcl_pattern_gen #(
  parameter int unsigned HALF_CYC = `RCL_FLASH_HALF_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Square wave
  output logic wave
);
  typedef struct packed {
    logic [31:0] cnt;
    logic wave;
  } rcl_gen_t;

  rcl_gen_t s, n;

  // Count one half period, then toggle
  always_comb begin
    n = s;
    if (s.cnt >= HALF_CYC - 32'h00000001) begin
      n.cnt = 32'h00000000;
      n.wave = ~s.wave;
    end else begin
      n.cnt = s.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign wave = s.wave;
endmodule // rcl_pattern_gen
`default_nettype wire

// ===== tb/rcl_led_props.sv
`timescale 1ns/1ps
`default_nettype none
module rcl_led_props #(
  parameter int unsigned NUM_PORTS = 2,
  parameter bit SAFETY_VARIANT = 1'b0,
  parameter int unsigned FLASH_HALF_CYC = 4,
  parameter int unsigned BLINK_HALF_CYC = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Indicators
  input wire rcl_pkg::rcl_panel_t panel,
  input wire logic [NUM_PORTS-1:0] port_activity_led,
  input wire logic [NUM_PORTS-1:0] port_link_led_green,
  input wire logic [NUM_PORTS-1:0] port_link_led_yellow
);
  logic [31:0] act_run_reg;
  logic [31:0] ab_run_reg;
  logic [31:0] ps_run_reg;

  // Lit runs; a flash never stays lit past one half period
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      act_run_reg <= 32'h0;
      ab_run_reg <= 32'h0;
      ps_run_reg <= 32'h0;
    end else begin
      act_run_reg <= port_activity_led[0] ? act_run_reg + 32'h1 : 32'h0;
      ab_run_reg <= (panel.unit_a && panel.unit_b) ?
        ab_run_reg + 32'h1 : 32'h0;
      ps_run_reg <= (panel.primary_role_led && panel.standby_role_led) ?
        ps_run_reg + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Bus handshake and indicator relations
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  req_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  idle_wait_a: assert property (!(avs_read || avs_write)
    |=> avs_waitrequest) else $error("answer without request");
  rst_quiet_a: assert property ($rose(rstn) |-> avs_waitrequest &&
    panel == '0 && port_activity_led == '0) else $error("reset not quiet");
  link_excl_a: assert property (!(port_link_led_green[0] &&
    port_link_led_yellow[0])) else $error("green and yellow together");
  card_nocfg_a: assert property (panel.no_config |->
    !panel.card_access && !panel.card_led_a) else $error("card lit");
  safety_off_a: assert property (!SAFETY_VARIANT |->
    !panel.safety_run_led && !panel.safety_mode_led) else $error("safety");
  act_flash_a: assert property (act_run_reg <= FLASH_HALF_CYC)
    else $error("activity lit too long");
  ab_both_a: assert property (ab_run_reg <= FLASH_HALF_CYC)
    else $error("A and B steady together");
  ps_both_a: assert property (ps_run_reg <= FLASH_HALF_CYC)
    else $error("primary and standby steady together");
  cover property (avs_read && !avs_waitrequest);
  cover property (port_activity_led[0]);
  cover property (panel.link_green);
endmodule // rcl_led_props

bind rcl_led_top rcl_led_props #(.NUM_PORTS(NUM_PORTS),
  .SAFETY_VARIANT(SAFETY_VARIANT), .FLASH_HALF_CYC(FLASH_HALF_CYC),
  .BLINK_HALF_CYC(BLINK_HALF_CYC)) chk_u (.core_clk(core_clk),
  .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .panel(panel),
  .port_activity_led(port_activity_led),
  .port_link_led_green(port_link_led_green),
  .port_link_led_yellow(port_link_led_yellow));
`default_nettype wire

// ===== tb/rcl_led_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rcl_led_top_bench;
  localparam int unsigned FH = 4;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  rcl_pkg::rcl_panel_t panel;
  logic [1:0] act, lg, ly;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] exp_q[$];
  logic [7:0] seed = 8'h5E;
  logic [31:0] msk[6] = '{32'hF, 32'h7F, 32'h7, 32'hFF0F, 32'h1F, 32'h3};
  // Role, state, link, port, card; expected class per indicator
  logic [15:0] tw[6][5] = '{'{16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
    '{16'h9, 16'h25, 16'h7, 16'h601, 16'h3},
    '{16'h6, 16'h6, 16'h3, 16'h903, 16'h17},
    '{16'h5, 16'h8, 16'h1, 16'hF00, 16'h1},
    '{16'hA, 16'h40, 16'h2, 16'h0, 16'h10},
    '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1B}};
  string te[6] = '{"FFOFFOOONOOOOOOOO", "NONNONNOOOOOFONNO",
    "ONFNFBFNOOOFFNOON", "FOOONOBOOOOOOOOOO", "OFOOOOOONOOOOOOOO",
    "FFOFFOONOOOOOOOOO"};

  rcl_led_top #(.NUM_PORTS(2), .SAFETY_VARIANT(1'b0),
    .FLASH_HALF_CYC(FH), .BLINK_HALF_CYC(10)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .panel(panel), .port_activity_led(act),
    .port_link_led_green(lg), .port_link_led_yellow(ly));

  // Clock
  always #10 core_clk = ~core_clk;

  // Next value of the stimulus register
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hold the request until waitrequest is seen low at an edge
  task automatic wt();
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wt();
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wt();
    avs_read <= 1'b0;
  endtask

  // Sort each indicator into off, on, flashing or blinking
  task automatic obs(input string e);
    int on_n[17] = '{default: 0};
    int run[17] = '{default: 0};
    int mx[17] = '{default: 0};
    int xs[17] = '{default: 0};
    logic [16:0] v;
    byte c;
    repeat (2) @(posedge core_clk);
    repeat (60) begin
      @(posedge core_clk);
      v = {panel, act, lg, ly};
      for (int i = 0; i < 17; i++) begin
        run[i] = (v[i] === 1'b1) ? run[i] + 1 : 0;
        on_n[i] += (v[i] === 1'b1) ? 1 : 0;
        xs[i] += $isunknown(v[i]) ? 1 : 0;
        if (run[i] > mx[i]) mx[i] = run[i];
      end
    end
    for (int i = 0; i < 17; i++) begin
      c = (xs[i] != 0) ? "X" : (on_n[i] == 0) ? "O" :
        (on_n[i] == 60) ? "N" : (mx[i] <= FH) ? "F" : "B";
      n_checks++;
      if (c != e[16-i]) begin
        err_total++;
        $display("MISMATCH t=%0t led %0d shows %s", $time, 16 - i, c);
      end
    end
  endtask

  // Read results against the oldest expectation
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      n_checks++;
      if (avs_readdata !== exp_q.pop_front()) begin
        err_total++;
        $display("MISMATCH t=%0t read %h", $time, avs_readdata);
      end
    end
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      $display("MISMATCH t=%0t timeout", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 6; k++) rd(8'(4 * k), 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0);
    rd(8'h20, 32'h0);
    // Random words, masked on readback
    for (int k = 0; k < 6; k++) begin
      wr(8'(4 * k), {4{seed}});
      rd(8'(4 * k), {4{seed}} & msk[k]);
      seed = lfsr_next(seed);
    end
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 5; j++) wr(8'(4 * j), {16'h0, tw[k][j]});
      obs(te[k]);
    end
    // All steady: the picture word must match the lit indicators
    for (int j = 0; j < 5; j++) begin
      wr(8'(4 * j), (j == 3) ? 32'h00000600 : {16'h0, tw[1][j]});
    end
    rd(8'h18, 32'h021005B0);
    give_verdict();
  end
endmodule // rcl_led_top_bench
`default_nettype wire
